// ---- src/asrr_pkg.sv ----
package asrr_pkg;
   localparam logic [7:0] OFS_CTRL1  = 8'h13;
   localparam logic [7:0] OFS_CTRL2  = 8'h14;
   localparam logic [7:0] OFS_CTRL3  = 8'h15;
   localparam logic [7:0] OFS_STAT1  = 8'h16;
   localparam logic [7:0] OFS_STAT2  = 8'h17;
   localparam logic [7:0] OFS_DATA   = 8'h18;
   localparam logic [7:0] OFS_BAUD   = 8'h19;
   localparam int unsigned C1_ENABLE = 6;
   localparam int unsigned C1_LEN9   = 4;
   localparam int unsigned C2_RXF_IE = 5;
   localparam int unsigned C2_RX_EN  = 2;
   localparam int unsigned C3_NINTH  = 7;
   localparam int unsigned C3_T8     = 6;
   localparam int unsigned C3_EN_W   = 4;
   localparam int unsigned C3_NF_IE  = 2;
   localparam int unsigned C3_FE_IE  = 1;
   localparam int unsigned S1_RXF    = 5;
   localparam int unsigned S1_NF     = 2;
   localparam int unsigned S1_FE     = 1;
   localparam int unsigned S2_BUSY   = 0;
   localparam int unsigned BAUD_W    = 6;
   localparam logic [4:0] RT_ZERO    = 5'h00;
   localparam logic [4:0] RT_FIRST   = 5'h01;
   localparam logic [4:0] RT3        = 5'h03;
   localparam logic [4:0] RT5        = 5'h05;
   localparam logic [4:0] RT7        = 5'h07;
   localparam logic [4:0] RT8        = 5'h08;
   localparam logic [4:0] RT9        = 5'h09;
   localparam logic [4:0] RT10       = 5'h0a;
   localparam logic [4:0] RT_LAST    = 5'h10;
   localparam logic [4:0] RT_STEP2   = 5'h02;
   localparam logic [3:0] BITS8      = 4'h8;
   localparam logic [3:0] BITS9      = 4'h9;
   localparam logic [2:0] HIST_IDLE  = 3'h7;
   localparam logic [2:0] SYNC_RST   = 3'h7;

   typedef enum logic [1:0] {ASRR_IDLE, ASRR_START, ASRR_DATA, ASRR_STOP} asrr_fsm_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } asrr_req_t;

   typedef struct packed {
      logic [2:0]        sync;
      logic              samp;
      logic [2:0]        hist;
      asrr_fsm_t         fsm;
      logic [4:0]        rt;
      logic [1:0]        vote;
      logic [3:0]        nbit;
      logic [8:0]        shreg;
      logic              prev_one;
      logic              edge_seen;
      logic [4:0]        since;
      logic [7:0]        ctrl1;
      logic [7:0]        ctrl2;
      logic              t8;
      logic [C3_EN_W-1:0] c3_en;
      logic [BAUD_W-1:0] baud;
      logic [BAUD_W-1:0] div;
      logic              tick;
      logic [7:0]        data;
      logic              ninth;
      logic              rxf;
      logic              nf;
      logic              fe;
      logic [7:0]        rdata;
   } asrr_st_t;
endpackage

// ---- src/asrr_rx.sv ----
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module asrr_rx (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire asrr_pkg::asrr_req_t bus_req,
   output logic [7:0]            rdata,
   input  wire logic             serial_in_pin,
   output logic                  irq
);
   asrr_pkg::asrr_st_t s_q;
   asrr_pkg::asrr_st_t s_d;
   logic [2:0]         v3;
   logic               maj;
   logic               noisy;
   logic               rx_on;
   logic               xfer;
   logic [3:0]         len;
   logic [7:0]         rd_val;

   always_comb begin
      s_d = s_q;
      xfer = 1'b0;
      rd_val = 8'h00;
      // first stage feeds only the second; the filter looks at stages two and three
      s_d.sync = {s_q.sync[1:0], serial_in_pin};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.samp = s_q.sync[2];
      end
      // oversample divider; period is baud + 1 clocks
      s_d.tick = 1'b0;
      if (s_q.div >= s_q.baud) begin
         s_d.div = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + {{(asrr_pkg::BAUD_W-1){1'b0}}, 1'b1};
      end
      v3 = {s_q.samp, s_q.vote};
      maj = (v3[0] & v3[1]) | (v3[0] & v3[2]) | (v3[1] & v3[2]);
      noisy = (|v3) & ~(&v3);
      rx_on = s_q.ctrl1[asrr_pkg::C1_ENABLE] & s_q.ctrl2[asrr_pkg::C2_RX_EN];
      len = s_q.ctrl1[asrr_pkg::C1_LEN9] ? asrr_pkg::BITS9 : asrr_pkg::BITS8;

      // register reads; flag clear comes first so a same-cycle set below wins
      if (bus_req.rd) begin
         case (bus_req.addr)
            asrr_pkg::OFS_CTRL1: rd_val = s_q.ctrl1;
            asrr_pkg::OFS_CTRL2: rd_val = s_q.ctrl2;
            asrr_pkg::OFS_CTRL3: begin
               rd_val[asrr_pkg::C3_NINTH] = s_q.ninth;
               rd_val[asrr_pkg::C3_T8] = s_q.t8;
               rd_val[asrr_pkg::C3_EN_W-1:0] = s_q.c3_en;
            end
            asrr_pkg::OFS_STAT1: begin
               rd_val[asrr_pkg::S1_RXF] = s_q.rxf;
               rd_val[asrr_pkg::S1_NF] = s_q.nf;
               rd_val[asrr_pkg::S1_FE] = s_q.fe;
               s_d.rxf = 1'b0;
               s_d.nf = 1'b0;
               s_d.fe = 1'b0;
            end
            asrr_pkg::OFS_STAT2: rd_val[asrr_pkg::S2_BUSY] = (s_q.fsm != asrr_pkg::ASRR_IDLE);
            asrr_pkg::OFS_DATA: rd_val = s_q.data;
            asrr_pkg::OFS_BAUD: rd_val[asrr_pkg::BAUD_W-1:0] = s_q.baud;
            default: rd_val = 8'h00;
         endcase
      end
      s_d.rdata = rd_val;

      // writes; the data buffer takes none on this receive-only block
      if (bus_req.wr) begin
         case (bus_req.addr)
            asrr_pkg::OFS_CTRL1: s_d.ctrl1 = bus_req.wdata;
            asrr_pkg::OFS_CTRL2: s_d.ctrl2 = bus_req.wdata;
            asrr_pkg::OFS_CTRL3: begin
               s_d.t8 = bus_req.wdata[asrr_pkg::C3_T8];
               s_d.c3_en = bus_req.wdata[asrr_pkg::C3_EN_W-1:0];
            end
            asrr_pkg::OFS_BAUD: s_d.baud = bus_req.wdata[asrr_pkg::BAUD_W-1:0];
            default: s_d.t8 = s_q.t8;
         endcase
      end

      if (s_q.tick) begin
         s_d.hist = {s_q.hist[1:0], s_q.samp};
         s_d.rt = s_q.rt + asrr_pkg::RT_FIRST;
         // falling edge after a 1 bit, remembered for realignment
         if (s_q.edge_seen) begin
            s_d.since = s_q.since + asrr_pkg::RT_FIRST;
         end
         if (s_q.prev_one && !s_q.edge_seen && s_q.hist[0] && !s_q.samp) begin
            s_d.edge_seen = 1'b1;
            s_d.since = asrr_pkg::RT_FIRST;
         end
         case (s_q.fsm)
            asrr_pkg::ASRR_IDLE: begin
               s_d.rt = asrr_pkg::RT_ZERO;
               if (rx_on && s_q.hist == asrr_pkg::HIST_IDLE && !s_q.samp) begin
                  s_d.fsm = asrr_pkg::ASRR_START;
                  // the falling sample itself was tick one, so the next tick is two
                  s_d.rt = asrr_pkg::RT_STEP2;
               end
            end
            asrr_pkg::ASRR_START: begin
               case (s_q.rt)
                  asrr_pkg::RT3: s_d.vote[0] = s_q.samp;
                  asrr_pkg::RT5: s_d.vote[1] = s_q.samp;
                  asrr_pkg::RT7: begin
                     if (maj) begin
                        s_d.fsm = asrr_pkg::ASRR_IDLE;
                        s_d.rt = asrr_pkg::RT_ZERO;
                     end else if (noisy) begin
                        s_d.nf = 1'b1;
                     end
                  end
                  asrr_pkg::RT8: s_d.vote[0] = s_q.samp;
                  asrr_pkg::RT9: s_d.vote[1] = s_q.samp;
                  asrr_pkg::RT10: begin
                     if (|v3) begin
                        s_d.nf = 1'b1;
                     end
                  end
                  asrr_pkg::RT_LAST: begin
                     s_d.fsm = asrr_pkg::ASRR_DATA;
                     s_d.rt = asrr_pkg::RT_FIRST;
                     s_d.nbit = 4'h0;
                     s_d.prev_one = 1'b0;
                     s_d.edge_seen = 1'b0;
                  end
                  default: s_d.vote = s_q.vote;
               endcase
            end
            asrr_pkg::ASRR_DATA: begin
               case (s_q.rt)
                  asrr_pkg::RT8: s_d.vote[0] = s_q.samp;
                  asrr_pkg::RT9: s_d.vote[1] = s_q.samp;
                  asrr_pkg::RT10: begin
                     s_d.shreg = {maj, s_q.shreg[8:1]};
                     if (noisy) begin
                        s_d.nf = 1'b1;
                     end
                     // realign so the edge counts as tick one of this bit
                     if (s_q.prev_one && !maj && s_q.edge_seen) begin
                        s_d.rt = s_q.since + asrr_pkg::RT_STEP2;
                     end
                     s_d.prev_one = maj;
                     s_d.edge_seen = 1'b0;
                  end
                  asrr_pkg::RT_LAST: begin
                     s_d.rt = asrr_pkg::RT_FIRST;
                     s_d.nbit = s_q.nbit + 4'h1;
                     if (s_q.nbit + 4'h1 == len) begin
                        s_d.fsm = asrr_pkg::ASRR_STOP;
                     end
                  end
                  default: s_d.vote = s_q.vote;
               endcase
            end
            asrr_pkg::ASRR_STOP: begin
               case (s_q.rt)
                  asrr_pkg::RT8: s_d.vote[0] = s_q.samp;
                  asrr_pkg::RT9: s_d.vote[1] = s_q.samp;
                  asrr_pkg::RT10: begin
                     xfer = 1'b1;
                     // in 8-bit mode the byte sits one place high after eight shifts
                     s_d.data = s_q.ctrl1[asrr_pkg::C1_LEN9] ? s_q.shreg[7:0]
                                                             : s_q.shreg[8:1];
                     s_d.ninth = s_q.shreg[8];
                     s_d.rxf = 1'b1;
                     if (!maj) begin
                        s_d.fe = 1'b1;
                     end
                     if (noisy) begin
                        s_d.nf = 1'b1;
                     end
                     s_d.fsm = asrr_pkg::ASRR_IDLE;
                     s_d.rt = asrr_pkg::RT_ZERO;
                  end
                  default: s_d.vote = s_q.vote;
               endcase
            end
            default: s_d.fsm = asrr_pkg::ASRR_IDLE;
         endcase
      end
      // disabling aborts a character; it is not completed later
      if (!rx_on) begin
         s_d.fsm = asrr_pkg::ASRR_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.sync <= asrr_pkg::SYNC_RST;
         s_q.samp <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign irq = (s_q.rxf & s_q.ctrl2[asrr_pkg::C2_RXF_IE])
              | (s_q.nf & s_q.c3_en[asrr_pkg::C3_NF_IE])
              | (s_q.fe & s_q.c3_en[asrr_pkg::C3_FE_IE]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   rx_full_set_a: assert property (
      xfer
      |=> s_q.rxf && s_q.data == $past(s_d.data))
      else $error("rx full not set after transfer");

   fe_with_full_a: assert property (
      $rose(s_q.fe)
      |-> $past(xfer) && s_q.rxf)
      else $error("framing error set apart from rx full");

   irq_level_a: assert property (
      s_q.rxf && s_q.ctrl2[asrr_pkg::C2_RXF_IE]
      |-> irq)
      else $error("rx full interrupt missing");

   ninth_copy_a: assert property (
      $past(xfer) && !$past(s_q.ctrl1[asrr_pkg::C1_LEN9])
      |-> s_q.ninth == s_q.data[7])
      else $error("ninth bit not a copy of bit 7");

   start_search_a: assert property (
      s_q.fsm == asrr_pkg::ASRR_START && $past(s_q.fsm) == asrr_pkg::ASRR_IDLE
      |-> $past(s_q.hist) == asrr_pkg::HIST_IDLE && !$past(s_q.samp)
      && s_q.rt == asrr_pkg::RT_STEP2)
      else $error("start taken without three ones then zero");

   start_fail_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_START
      && s_q.rt == asrr_pkg::RT7 && maj && rx_on
      |=> s_q.fsm == asrr_pkg::ASRR_IDLE && s_q.rt == asrr_pkg::RT_ZERO)
      else $error("failed start not abandoned");

   start_noise_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_START && s_q.rt == asrr_pkg::RT7
      && !maj && noisy |=> s_q.nf)
      else $error("start noise not flagged");

   stop_frame_a: assert property (
      xfer && !maj
      |=> s_q.fe)
      else $error("bad stop bit not flagged");

   data_phase_a: assert property (
      s_q.fsm == asrr_pkg::ASRR_DATA && $past(s_q.fsm) == asrr_pkg::ASRR_START
      |-> s_q.rt == asrr_pkg::RT_FIRST
      && s_q.nbit == 4'h0)
      else $error("phase not restarted after start bit");

   data_noise_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_DATA && s_q.rt == asrr_pkg::RT10
      && noisy && rx_on |=> s_q.nf)
      else $error("data noise not flagged");

   data_hold_a: assert property (
      !xfer
      |=> $stable(s_q.data))
      else $error("data buffer changed without a character");

   rdata_idle_a: assert property (
      !$past(bus_req.rd)
      |-> rdata == 8'h00)
      else $error("read data outside the read cycle");

   ninth_nine_a: assert property (
      xfer && s_q.ctrl1[asrr_pkg::C1_LEN9]
      |=> s_q.ninth == $past(s_q.shreg[8]))
      else $error("ninth bit not taken in 9-bit mode");

   tick_rate_a: assert property (
      s_q.tick && s_q.baud != '0
      |=> !s_q.tick)
      else $error("oversample tick longer than one cycle");

   sample_hold_a: assert property (
      !s_q.tick
      |=> $stable(s_q.hist))
      else $error("line sampled without a tick");

   sync_filter_a: assert property (
      s_q.sync[1] != s_q.sync[2]
      |=> $stable(s_q.samp))
      else $error("filtered line moved on disagreeing stages");

   idle_rt_a: assert property (
      s_q.fsm == asrr_pkg::ASRR_IDLE && $past(s_q.fsm) == asrr_pkg::ASRR_IDLE
      && $past(s_q.tick) |-> s_q.rt == asrr_pkg::RT_ZERO)
      else $error("phase counter runs while searching");

   read_clear_a: assert property (
      bus_req.rd && bus_req.addr == asrr_pkg::OFS_STAT1 && !s_q.tick
      |=> !s_q.rxf && !s_q.nf && !s_q.fe)
      else $error("status read did not clear flags");

   full_sticky_a: assert property (
      s_q.rxf && !(bus_req.rd && bus_req.addr == asrr_pkg::OFS_STAT1)
      |=> s_q.rxf)
      else $error("rx full dropped without a status read");

   noise_sticky_a: assert property (
      s_q.nf && !(bus_req.rd && bus_req.addr == asrr_pkg::OFS_STAT1)
      |=> s_q.nf)
      else $error("noise flag dropped without a status read");

   frame_sticky_a: assert property (
      s_q.fe && !(bus_req.rd && bus_req.addr == asrr_pkg::OFS_STAT1)
      |=> s_q.fe)
      else $error("framing flag dropped without a status read");

   rxf_only_xfer_a: assert property (
      !s_q.rxf && !xfer
      |=> !s_q.rxf)
      else $error("rx full set without a character");

   fe_only_xfer_a: assert property (
      !s_q.fe && !xfer
      |=> !s_q.fe)
      else $error("framing flag set without a character");

   data_one_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_DATA && s_q.rt == asrr_pkg::RT10
      && s_q.vote == 2'h3 && s_q.samp |=> s_q.shreg[8])
      else $error("data bit of ones not taken as one");

   data_zero_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_DATA && s_q.rt == asrr_pkg::RT10
      && s_q.vote == 2'h0 && !s_q.samp |=> !s_q.shreg[8])
      else $error("data bit of zeros not taken as zero");

   data_quiet_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_DATA && s_q.rt == asrr_pkg::RT10
      && s_q.vote == {2{s_q.samp}} && !s_q.nf |=> !s_q.nf)
      else $error("noise flagged on agreeing data samples");

   start_quiet_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_START && s_q.rt == asrr_pkg::RT7
      && v3 == 3'h0 && !s_q.nf |=> !s_q.nf)
      else $error("noise flagged on a clean start");

   start_fail_quiet_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_START && s_q.rt == asrr_pkg::RT7
      && maj && !s_q.nf |=> !s_q.nf)
      else $error("noise flagged on a failed start");

   start_late_a: assert property (
      s_q.tick && s_q.fsm == asrr_pkg::ASRR_START && s_q.rt == asrr_pkg::RT10
      && s_q.samp && rx_on |=> s_q.nf && s_q.fsm == asrr_pkg::ASRR_START)
      else $error("late start sample not flagged as noise");

   stop_noise_a: assert property (
      xfer && noisy
      |=> s_q.nf)
      else $error("stop noise not flagged");

   stop_good_a: assert property (
      xfer && maj && !s_q.fe
      |=> !s_q.fe)
      else $error("framing flag on a good stop bit");

   nine_bits_a: assert property (
      s_q.fsm == asrr_pkg::ASRR_STOP && $past(s_q.fsm) == asrr_pkg::ASRR_DATA
      |-> s_q.nbit == ($past(s_q.ctrl1[asrr_pkg::C1_LEN9]) ? asrr_pkg::BITS9
                                                          : asrr_pkg::BITS8))
      else $error("wrong number of data bits");

   irq_quiet_a: assert property (
      !s_q.rxf && !s_q.nf && !s_q.fe
      |-> !irq)
      else $error("interrupt without a flag");
endmodule // asrr_rx

// ---- tb/asrr_tx_model.sv ----
`timescale 1ns/1ps
module asrr_tx_model (
   input  wire logic clk,
   output logic      line
);
   // tick is 4 clocks with the divisor the bench writes, so one bit is 64 clocks
   localparam int BITC = 64;

   initial line = 1'b1;

   // gl: start of a 4-clock inverted glitch, counted from the start edge; 9999 for none
   // 4 clocks wide so it covers exactly one oversample point whatever the tick phase
   task automatic send(input logic [8:0] d, input int nb, input logic stp, input int gl);
      logic v;
      repeat (4 * BITC) @(posedge clk) line <= 1'b1;
      if (nb == 0) begin
         // runt start: low for two ticks only, then back to idle
         repeat (8) @(posedge clk) line <= 1'b0;
         repeat (BITC) @(posedge clk) line <= 1'b1;
      end else begin
         for (int c = 0; c < (nb + 2) * BITC; c++) begin
            int b;
            b = c / BITC;
            v = (b == 0) ? 1'b0 : (b > nb) ? stp : d[b-1];
            @(posedge clk) line <= (c >= gl && c < gl + 4) ? ~v : v;
         end
         @(posedge clk) line <= 1'b1;
      end
   endtask
endmodule // asrr_tx_model

// ---- tb/asrr_rx_bench.sv ----
`timescale 1ns/1ps
module asrr_rx_bench;
   logic                clk;
   logic                sys_rst;
   asrr_pkg::asrr_req_t req;
   logic [7:0]          rdata;
   logic                line;
   logic                irq;
   int                  compares;
   int                  miscompares;
   // start RT5, start RT9, data bit 0 RT10, stop RT10 in 9-bit frames
   int                  offs [4] = '{16, 32, 100, 676};

   asrr_rx dut_u (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .bus_req       (req),
      .rdata         (rdata),
      .serial_in_pin (line),
      .irq           (irq)
   );

   asrr_tx_model tx_u (
      .clk  (clk),
      .line (line)
   );

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd   <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), rdata, exp);
   endtask

   task automatic end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // all frames are finite, so this only fires on a hung run
   initial begin
      #900000;
      miscompares++;
      end_sim;
   end

   initial begin
      sys_rst = 1'b1;
      req     = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 8'h13; a <= 8'h1a; a++) rd(8'(a), 8'h00);
      wr(asrr_pkg::OFS_CTRL3, 8'hff);
      rd(asrr_pkg::OFS_CTRL3, 8'h4f);
      wr(asrr_pkg::OFS_CTRL3, 8'h00);
      wr(asrr_pkg::OFS_BAUD, 8'h03);
      rd(asrr_pkg::OFS_BAUD, 8'h03);
      wr(asrr_pkg::OFS_CTRL1, 8'h40);
      wr(asrr_pkg::OFS_CTRL2, 8'h24);
      tx_u.send(9'h0a5, 8, 1'b1, 9999);
      chk("irq", {7'h00, irq}, 8'h01);
      rd(asrr_pkg::OFS_STAT2, 8'h00);
      rd(asrr_pkg::OFS_STAT1, 8'h20);
      chk("irq", {7'h00, irq}, 8'h00);
      rd(asrr_pkg::OFS_DATA, 8'ha5);
      rd(asrr_pkg::OFS_CTRL3, 8'h80);
      wr(asrr_pkg::OFS_DATA, 8'hff);
      rd(asrr_pkg::OFS_DATA, 8'ha5);
      // a runt start must be dropped and the next frame still caught cleanly
      tx_u.send(9'h000, 0, 1'b1, 9999);
      tx_u.send(9'h0c3, 8, 1'b1, 9999);
      rd(asrr_pkg::OFS_STAT1, 8'h20);
      rd(asrr_pkg::OFS_DATA, 8'hc3);
      wr(asrr_pkg::OFS_CTRL2, 8'h04);
      wr(asrr_pkg::OFS_CTRL3, 8'h02);
      tx_u.send(9'h03c, 8, 1'b0, 9999);
      chk("irq", {7'h00, irq}, 8'h01);
      rd(asrr_pkg::OFS_STAT1, 8'h22);
      rd(asrr_pkg::OFS_DATA, 8'h3c);
      rd(asrr_pkg::OFS_CTRL3, 8'h02);
      tx_u.send(9'h011, 8, 1'b1, 9999);
      chk("irq", {7'h00, irq}, 8'h00);
      rd(asrr_pkg::OFS_STAT1, 8'h20);
      wr(asrr_pkg::OFS_CTRL1, 8'h50);
      tx_u.send(9'h15a, 9, 1'b1, 9999);
      rd(asrr_pkg::OFS_DATA, 8'h5a);
      rd(asrr_pkg::OFS_CTRL3, 8'h82);
      for (int i = 0; i < 4; i++) begin
         tx_u.send(9'h0a5, 9, 1'b1, offs[i]);
         rd(asrr_pkg::OFS_STAT1, 8'h24);
         rd(asrr_pkg::OFS_DATA, 8'ha5);
      end
      end_sim;
   end
endmodule // asrr_rx_bench
